// File: dss_cfg.svh
// constants for the dual switch serial slave
`ifndef DSS_CFG_SVH
`define DSS_CFG_SVH
`define DSS_FRAME_BITS 8
`define DSS_CMD_MSB 7
`define DSS_CMD_LSB 4
`define DSS_DIAG_RESET 8'h00
`define DSS_CTRL_RESET 8'h00
`endif

// File: dss_pkg.sv
// types for the dual switch serial slave
`default_nettype none
package dss_pkg;
    // serial pins as they arrive and leave
    typedef struct packed {
        logic cs_n;
        logic sclk;
        logic si;
    } dss_pins_in_t;
    typedef struct packed {
        logic so;
        logic so_oe_n;
    } dss_pins_out_t;
    // frame delivered to the core
    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } dss_frame_t;
endpackage
`default_nettype wire

// File: dss_spi_slave.sv
// serial control and diagnosis slave port of a dual channel low-side switch
`timescale 1ns/1ps
`default_nettype none
`include "dss_cfg.svh"
module dss_spi_slave #(
    parameter logic [3:0] SLEEP_CMD = 4'hf,
    parameter logic [15:0] VALID_CMDS = 16'hffff
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire dss_pkg::dss_pins_in_t pins_in,
    output var dss_pkg::dss_pins_out_t pins_out,
    input wire logic [7:0] diag_event,
    output logic [7:0] ctrl_out,
    output logic sleep_pulse,
    output logic [7:0] diag_flags
);
    import dss_pkg::*;

    // ************************************************
    // state
    // ************************************************
    typedef struct packed {
        logic [2:0] cs_s;
        logic [2:0] ck_s;
        logic [1:0] si_s;
        logic [7:0] shift;
        logic so;
        logic oe_n;
        logic [3:0] cnt;
        logic [7:0] diag;
        logic [7:0] ctrl;
        logic sleep;
    } dss_state_t;

    dss_state_t st_reg, st_next;
    // one-clock strobes and the select level taken from the synchronised pins
    logic cs_low, cs_fall, cs_rise, ck_fall, ck_rise;

    // edge detect only on the second and third stages, never the first
    assign cs_low = ~st_reg.cs_s[1];
    assign cs_fall = st_reg.cs_s[2] & ~st_reg.cs_s[1];
    assign cs_rise = ~st_reg.cs_s[2] & st_reg.cs_s[1];
    assign ck_fall = st_reg.ck_s[2] & ~st_reg.ck_s[1];
    assign ck_rise = ~st_reg.ck_s[2] & st_reg.ck_s[1];

    // command is valid if its bit in the mask is set
    function automatic logic cmd_ok(input logic [3:0] c);
        cmd_ok = VALID_CMDS[c];
    endfunction

    // command field of a received byte; decoded in several places
    function automatic logic [3:0] cmd_of(input logic [7:0] b);
        cmd_of = b[`DSS_CMD_MSB:`DSS_CMD_LSB];
    endfunction

    // falling clock edges that make a whole frame; a chain saturates here
    localparam logic [3:0] FULL_CNT = 4'(`DSS_FRAME_BITS);

    // ************************************************
    // next state
    // ************************************************
    always_comb begin
        st_next = st_reg;
        st_next.sleep = 1'b0;
        // two flops before any logic reads a pin
        st_next.cs_s = {st_reg.cs_s[1:0], pins_in.cs_n};
        st_next.ck_s = {st_reg.ck_s[1:0], pins_in.sclk};
        st_next.si_s = {st_reg.si_s[0], pins_in.si};
        // latch events; set wins over the clear below
        st_next.diag = st_reg.diag | diag_event;
        // select fall: reload from the flags and drive the msb at once
        if (cs_fall) begin
            st_next.shift = st_reg.diag | diag_event;
            st_next.so = st_next.shift[`DSS_FRAME_BITS-1];
            st_next.oe_n = 1'b0;
            st_next.cnt = 4'h0;
        end else if (cs_low && st_reg.oe_n == 1'b0) begin
            if (ck_fall) begin
                // sample; si already settled for a whole high phase
                st_next.shift = {st_reg.shift[6:0], st_reg.si_s[1]};
                if (st_reg.cnt != FULL_CNT) begin
                    st_next.cnt = st_reg.cnt + 4'h1;
                end
            end
            // the new bit shows a few clocks after the pin edge, well inside a half period
            if (ck_rise) begin
                st_next.so = st_reg.shift[`DSS_FRAME_BITS-1];
            end
        end
        // select rise: float the output, then judge the frame
        if (cs_rise) begin
            st_next.oe_n = 1'b1;
            // only a full frame counts; longer chain frames keep last eight
            if (st_reg.cnt == FULL_CNT) begin
                st_next.diag = diag_event;
                if (cmd_ok(cmd_of(st_reg.shift))) begin
                    st_next.ctrl = st_reg.shift;
                    if (cmd_of(st_reg.shift) == SLEEP_CMD) begin
                        st_next.sleep = 1'b1;
                    end
                end
            end
        end
        // sleep restores the registers to defaults
        if (st_reg.sleep) begin
            st_next.ctrl = `DSS_CTRL_RESET;
            st_next.diag = `DSS_DIAG_RESET | diag_event;
        end
    end

    // ************************************************
    // registers
    // ************************************************
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st_reg <= '0;
            // select sync preset to idle high, so release gives no false fall
            st_reg.cs_s <= 3'h7;
            st_reg.oe_n <= 1'b1;
            st_reg.diag <= `DSS_DIAG_RESET;
            st_reg.ctrl <= `DSS_CTRL_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    // outputs come straight from the state flops, so pins never glitch
    assign pins_out.so = st_reg.so;
    assign pins_out.so_oe_n = st_reg.oe_n;
    assign ctrl_out = st_reg.ctrl;
    assign sleep_pulse = st_reg.sleep;
    assign diag_flags = st_reg.diag;

    // ************************************************
    // checks
    // ************************************************
    // pin and shifter behaviour around select
    a_float_idle: assert property (@(posedge clk_sys) disable iff (rst)
        st_reg.cs_s[2] && st_reg.cs_s[1] |-> ##1 pins_out.so_oe_n)
        else $error("output driven while select high");
    a_drive_fall: assert property (@(posedge clk_sys) disable iff (rst)
        cs_fall |=> !pins_out.so_oe_n)
        else $error("output not driven after select fall");
    a_oe_rise: assert property (@(posedge clk_sys) disable iff (rst)
        cs_rise |=> pins_out.so_oe_n)
        else $error("output still driven after select rise");
    a_idle_shift: assert property (@(posedge clk_sys) disable iff (rst)
        st_reg.cs_s[1] |=> $stable(st_reg.shift))
        else $error("shifter moved while deselected");
    // shifting
    a_fresh_cnt: assert property (@(posedge clk_sys) disable iff (rst)
        cs_fall |=> st_reg.cnt == 4'h0)
        else $error("bit count not restarted");
    a_load_diag: assert property (@(posedge clk_sys) disable iff (rst)
        cs_fall |=> st_reg.shift == ($past(st_reg.diag) | $past(diag_event)))
        else $error("diagnosis not loaded");
    a_shift_in: assert property (@(posedge clk_sys) disable iff (rst)
        cs_low && !st_reg.oe_n && ck_fall && !cs_fall
        |=> st_reg.shift[0] == $past(st_reg.si_s[1]))
        else $error("input bit not captured");
    a_shift_out: assert property (@(posedge clk_sys) disable iff (rst)
        cs_low && !st_reg.oe_n && ck_rise && !cs_fall && !cs_rise
        |=> pins_out.so == $past(st_reg.shift[7]))
        else $error("output bit not advanced");
    a_so_hold: assert property (@(posedge clk_sys) disable iff (rst)
        !cs_fall && !ck_rise |=> $stable(pins_out.so))
        else $error("output bit moved without clock rise");
    a_cnt_max: assert property (@(posedge clk_sys) disable iff (rst)
        st_reg.cnt <= FULL_CNT)
        else $error("bit count ran past a frame");
    // frame acceptance and flags
    a_ctrl_load: assert property (@(posedge clk_sys) disable iff (rst)
        cs_rise && st_reg.cnt == FULL_CNT && cmd_ok(cmd_of(st_reg.shift)) && !st_reg.sleep
        |=> ctrl_out == $past(st_reg.shift))
        else $error("control not updated");
    a_ctrl_hold: assert property (@(posedge clk_sys) disable iff (rst)
        !cs_rise && !st_reg.sleep |=> $stable(ctrl_out))
        else $error("control changed outside frame end");
    a_refuse_cmd: assert property (@(posedge clk_sys) disable iff (rst)
        cs_rise && !cmd_ok(cmd_of(st_reg.shift)) && !st_reg.sleep |=> $stable(ctrl_out))
        else $error("invalid command acted upon");
    a_short_keep: assert property (@(posedge clk_sys) disable iff (rst)
        cs_rise && st_reg.cnt != FULL_CNT && !st_reg.sleep |=> $stable(ctrl_out))
        else $error("short frame acted upon");
    a_diag_clear: assert property (@(posedge clk_sys) disable iff (rst)
        cs_rise && st_reg.cnt == FULL_CNT |=> diag_flags == $past(diag_event))
        else $error("diagnosis not cleared");
    a_diag_keep: assert property (@(posedge clk_sys) disable iff (rst)
        !cs_rise && !st_reg.sleep
        |=> (diag_flags & $past(st_reg.diag)) == $past(st_reg.diag))
        else $error("diagnosis flag lost");
    a_sleep_rst: assert property (@(posedge clk_sys) disable iff (rst)
        sleep_pulse |=> ctrl_out == `DSS_CTRL_RESET)
        else $error("sleep did not reset control");
    a_sleep_once: assert property (@(posedge clk_sys) disable iff (rst)
        sleep_pulse |=> !sleep_pulse)
        else $error("sleep pulse longer than one cycle");
    // main scenarios
    c_frame: cover property (@(posedge clk_sys) disable iff (rst)
        cs_rise && st_reg.cnt == FULL_CNT);
    c_sleep: cover property (@(posedge clk_sys) disable iff (rst) sleep_pulse);
    c_short: cover property (@(posedge clk_sys) disable iff (rst)
        cs_rise && st_reg.cnt != FULL_CNT);
    c_refused: cover property (@(posedge clk_sys) disable iff (rst)
        cs_rise && st_reg.cnt == FULL_CNT && !cmd_ok(cmd_of(st_reg.shift)));
    c_idle_clock: cover property (@(posedge clk_sys) disable iff (rst)
        ck_rise && !cs_low);
endmodule // dss_spi_slave
`default_nettype wire

// File: dss_host.sv
// host master model that drives the serial pins of the slave
`timescale 1ns/1ps
`default_nettype none
module dss_host (
    input wire logic clk_sys,
    output var dss_pkg::dss_pins_in_t pins_in,
    input wire dss_pkg::dss_pins_out_t pins_out
);
    import dss_pkg::*;
    // idle lines rest at their pull levels: select high, clock and data low
    initial pins_in = '{1'b1, 1'b0, 1'b0};
    // a floating output reads as the inverse of its last level, so late drive shows
    logic so_line;
    assign so_line = pins_out.so_oe_n ? ~pins_out.so : pins_out.so;
    // ********************
    // frame task
    // ********************
    task automatic wt(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    // n bits msb first; half of the 80 ns link period is 8 clocks
    // with sel low the select stays high, so clock and data toggle unseen
    task automatic xfer(input logic [15:0] tx, input int n, input logic sel,
        output logic [15:0] rx);
        rx = 16'h0000;
        pins_in.cs_n <= ~sel;
        wt(40);
        for (int i = n - 1; i >= 0; i--) begin
            wt(4); // keeps data hold after the falling clock
            pins_in.si <= tx[i];
            wt(4);
            pins_in.sclk <= 1'b1;
            wt(8);
            // sampled at the falling clock, after the rise has moved the bit out
            rx = {rx[14:0], so_line};
            pins_in.sclk <= 1'b0;
        end
        wt(40);
        pins_in.si <= 1'b0;
        pins_in.cs_n <= 1'b1;
        wt(60);
    endtask
endmodule // dss_host
`default_nettype wire

// File: testbench.sv
// self-checking bench for the dual switch serial slave
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import dss_pkg::*;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [7:0] diag_event = 8'h00;
    dss_pins_in_t pins_in;
    dss_pins_out_t pins_out;
    logic [7:0] ctrl_out;
    logic [7:0] diag_flags;
    logic sleep_pulse;
    logic [15:0] rx;
    int err_total = 0;
    int num_checks = 0;
    int cyc = 0;
    int sleeps = 0;
    // rows: command byte above, diagnosis to raise below
    logic [15:0] rows [3] = '{16'ha53c, 16'h5ac3, 16'h0180};
    // command e made invalid so a refused frame can be tried
    dss_spi_slave #(.VALID_CMDS(16'hbfff)) u_dss_spi_slave (.clk_sys(clk_sys),
        .rst(rst), .pins_in(pins_in), .pins_out(pins_out), .diag_event(diag_event),
        .ctrl_out(ctrl_out), .sleep_pulse(sleep_pulse), .diag_flags(diag_flags));
    dss_host u_dss_host (.clk_sys(clk_sys), .pins_in(pins_in), .pins_out(pins_out));
    // ********************
    // clock, watchdog and checks
    // ********************
    initial forever #2.5 clk_sys = ~clk_sys;
    // cycle ceiling well above the few thousand the tests need
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (sleep_pulse === 1'b1) sleeps <= sleeps + 1;
        if (cyc == 10000) begin
            err_total++;
            final_report();
        end
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // one clock of event is enough, the flags must hold it
    task automatic raise(input logic [7:0] d);
        diag_event <= d;
        @(posedge clk_sys);
        diag_event <= 8'h00;
        repeat (2) @(posedge clk_sys);
    endtask
    initial begin
        repeat (12) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        chk({ctrl_out, diag_flags}, 16'h0000);
        chk({14'h0000, pins_out}, 16'h0001);
        $display("power-up reset done");
        foreach (rows[i]) begin
            raise(rows[i][7:0]);
            chk({8'h00, diag_flags}, {8'h00, rows[i][7:0]});
            u_dss_host.xfer({8'h00, rows[i][15:8]}, 8, 1'b1, rx);
            chk(rx, {8'h00, rows[i][7:0]});
            chk({ctrl_out, diag_flags}, {rows[i][15:8], 8'h00});
            chk({15'h0000, pins_out.so_oe_n}, 16'h0001);
            $display("row %0d done", i);
        end
        raise(8'h21);
        u_dss_host.xfer(16'h0077, 7, 1'b1, rx);
        chk({ctrl_out, diag_flags}, 16'h0121);
        u_dss_host.xfer(16'h00ff, 8, 1'b0, rx);
        chk({ctrl_out, diag_flags}, 16'h0121);
        chk({15'h0000, pins_out.so_oe_n}, 16'h0001);
        $display("short and unselected frames done");
        u_dss_host.xfer(16'h3c42, 16, 1'b1, rx);
        chk({rx[15:8], ctrl_out}, 16'h2142);
        chk({8'h00, rx[7:0]}, 16'h003c);
        // refused command while control holds a non-default byte; flags still clear
        raise(8'h10);
        u_dss_host.xfer(16'h00e7, 8, 1'b1, rx);
        chk(rx, 16'h0010);
        chk({ctrl_out, diag_flags}, 16'h4200);
        u_dss_host.xfer(16'h00f5, 8, 1'b1, rx);
        chk({sleeps[7:0], ctrl_out}, 16'h0100);
        $display("chain, refused and sleep frames done");
        // reset in mid-run with control and flags both set
        u_dss_host.xfer(16'h0033, 8, 1'b1, rx);
        raise(8'h66);
        chk({ctrl_out, diag_flags}, 16'h3366);
        rst <= 1'b1;
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        chk({ctrl_out, diag_flags}, 16'h0000);
        chk({14'h0000, pins_out}, 16'h0001);
        u_dss_host.xfer(16'h0024, 8, 1'b1, rx);
        chk({rx[7:0], ctrl_out}, 16'h0024);
        $display("mid-run reset done");
        final_report();
    end
endmodule // testbench
`default_nettype wire
